/* File: inc/upr_pkg.sv */
// Summary of operation
// - Each channel owns its registers; a 3-bit offset picks one of eight.
// - Page 0 offset 0: writes go to transmit holding, reads return receive buffer.
// - Pages 0 and 1 offset 2: writes fifo control, reads interrupt status.
// - Line control is read/write at offset 3 in every page.
// - Page 0 offset 1 is the read/write interrupt enable register.
// - Pages 0/1: offset 5 line status, 6 modem status read-only; 7 scratch.
// - Modem control is read/write at offset 4 in pages 0, 1 and 2.
// - Line control bit 7 set, not key: offsets 0 and 1 are divisor bytes.
// - Page 2: offset 0 empty, 1 write-only global control, 2 global status.
// - Page 2 offsets 5, 6, 7 read tx count, rx count, flow status.
// - Page 3: auto toggle, enhanced feature, resume and halt characters.
// - Page 4: additional feature, resend count, triggers, flow thresholds.
// - Page select read/write at offset 0 with key; bit 0 picks page 3/4.
// - Low and high divisor bytes form one 16-bit baud divisor.
`default_nettype none
package upr_pkg;
    localparam int          OFS_W         = 3;
    localparam int          DATA_W        = 8;
    localparam int          NUM_SLOTS     = 19;
    localparam int          SLOT_W        = 5;
    localparam logic [2:0]  OFS_0         = 3'h0;
    localparam logic [2:0]  OFS_1         = 3'h1;
    localparam logic [2:0]  OFS_2         = 3'h2;
    localparam logic [2:0]  OFS_3         = 3'h3;
    localparam logic [2:0]  OFS_4         = 3'h4;
    localparam logic [2:0]  OFS_5         = 3'h5;
    localparam logic [2:0]  OFS_6         = 3'h6;
    localparam logic [2:0]  OFS_7         = 3'h7;
    localparam logic [7:0]  ENH_KEY       = 8'hbf;
    localparam int          LINE_PG_BIT   = 7;
    localparam int          MODEM_PG_BIT  = 6;
    localparam int          SEL_PG_BIT    = 0;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  RDATA_RESET   = 8'h00;
    // Storage slots of the read/write registers
    localparam logic [4:0]  SLOT_IEN      = 5'h00;
    localparam logic [4:0]  SLOT_DVL      = 5'h01;
    localparam logic [4:0]  SLOT_DVH      = 5'h02;
    localparam logic [4:0]  SLOT_LIN      = 5'h03;
    localparam logic [4:0]  SLOT_MDM      = 5'h04;
    localparam logic [4:0]  SLOT_SCR      = 5'h05;
    localparam logic [4:0]  SLOT_PGS      = 5'h06;
    localparam logic [4:0]  SLOT_ATG      = 5'h07;
    localparam logic [4:0]  SLOT_ENH      = 5'h08;
    localparam logic [4:0]  SLOT_RES1     = 5'h09;
    localparam logic [4:0]  SLOT_RES2     = 5'h0a;
    localparam logic [4:0]  SLOT_HLT1     = 5'h0b;
    localparam logic [4:0]  SLOT_HLT2     = 5'h0c;
    localparam logic [4:0]  SLOT_ADF      = 5'h0d;
    localparam logic [4:0]  SLOT_RSND     = 5'h0e;
    localparam logic [4:0]  SLOT_TXTG     = 5'h0f;
    localparam logic [4:0]  SLOT_RXTG     = 5'h10;
    localparam logic [4:0]  SLOT_FUP      = 5'h11;
    localparam logic [4:0]  SLOT_FLO      = 5'h12;

    typedef enum logic [2:0] {
        UPR_PAGE0 = 3'b000,
        UPR_PAGE1 = 3'b001,
        UPR_PAGE2 = 3'b011,
        UPR_PAGE3 = 3'b010,
        UPR_PAGE4 = 3'b110
    } upr_page_e;

    typedef enum logic [3:0] {
        UPR_RD_NONE  = 4'h0,
        UPR_RD_SLOT  = 4'h1,
        UPR_RD_RXBUF = 4'h2,
        UPR_RD_ISTAT = 4'h3,
        UPR_RD_LSTAT = 4'h4,
        UPR_RD_MSTAT = 4'h5,
        UPR_RD_GSTAT = 4'h6,
        UPR_RD_TXCNT = 4'h7,
        UPR_RD_RXCNT = 4'h8,
        UPR_RD_FSTAT = 4'h9
    } upr_rd_e;

    typedef enum logic [2:0] {
        UPR_WR_NONE = 3'h0,
        UPR_WR_SLOT = 3'h1,
        UPR_WR_TXH  = 3'h2,
        UPR_WR_FIFO = 3'h3,
        UPR_WR_GCTL = 3'h4
    } upr_wr_e;
endpackage
`default_nettype wire

/* File: design/upr_reg8.sv */
`default_nettype none
module upr_reg8
    import upr_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = CFG_RESET
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [7:0] d,
    output var  logic [7:0] q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_VAL;
        end else if (we) begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

/* File: design/upr_page_decode.sv */
`default_nettype none
module upr_page_decode
    import upr_pkg::*;
(
    input  wire logic [7:0] line_control,
    input  wire logic       modem_page_bit,
    input  wire logic       page_bit,
    input  wire logic [2:0] offset,
    output var  upr_page_e  page,
    output var  upr_rd_e    rd_kind,
    output var  upr_wr_e    wr_kind,
    output var  logic [4:0] slot
);
    always_comb begin
        if (line_control == ENH_KEY) begin
            page = page_bit ? UPR_PAGE4 : UPR_PAGE3;
        end else if (line_control[LINE_PG_BIT]) begin
            page = UPR_PAGE1;
        end else if (modem_page_bit) begin
            page = UPR_PAGE2;
        end else begin
            page = UPR_PAGE0;
        end
    end

    // Default is the empty location: nothing stored, zero read back
    always_comb begin
        rd_kind = UPR_RD_NONE;
        wr_kind = UPR_WR_NONE;
        slot    = SLOT_IEN;
        if (offset == OFS_3) begin
            rd_kind = UPR_RD_SLOT;
            wr_kind = UPR_WR_SLOT;
            slot    = SLOT_LIN;
        end else begin
            case (page)
                UPR_PAGE0, UPR_PAGE1: begin
                    case (offset)
                        OFS_0: begin
                            if (page == UPR_PAGE0) begin
                                rd_kind = UPR_RD_RXBUF;
                                wr_kind = UPR_WR_TXH;
                            end else begin
                                rd_kind = UPR_RD_SLOT;
                                wr_kind = UPR_WR_SLOT;
                                slot    = SLOT_DVL;
                            end
                        end
                        OFS_1: begin
                            rd_kind = UPR_RD_SLOT;
                            wr_kind = UPR_WR_SLOT;
                            slot    = (page == UPR_PAGE0) ? SLOT_IEN : SLOT_DVH;
                        end
                        OFS_2: begin
                            rd_kind = UPR_RD_ISTAT;
                            wr_kind = UPR_WR_FIFO;
                        end
                        OFS_4: begin
                            rd_kind = UPR_RD_SLOT;
                            wr_kind = UPR_WR_SLOT;
                            slot    = SLOT_MDM;
                        end
                        OFS_5: rd_kind = UPR_RD_LSTAT;
                        OFS_6: rd_kind = UPR_RD_MSTAT;
                        OFS_7: begin
                            rd_kind = UPR_RD_SLOT;
                            wr_kind = UPR_WR_SLOT;
                            slot    = SLOT_SCR;
                        end
                        default: rd_kind = UPR_RD_NONE;
                    endcase
                end
                UPR_PAGE2: begin
                    case (offset)
                        OFS_1: wr_kind = UPR_WR_GCTL;
                        OFS_2: rd_kind = UPR_RD_GSTAT;
                        OFS_4: begin
                            rd_kind = UPR_RD_SLOT;
                            wr_kind = UPR_WR_SLOT;
                            slot    = SLOT_MDM;
                        end
                        OFS_5: rd_kind = UPR_RD_TXCNT;
                        OFS_6: rd_kind = UPR_RD_RXCNT;
                        OFS_7: rd_kind = UPR_RD_FSTAT;
                        default: rd_kind = UPR_RD_NONE;
                    endcase
                end
                UPR_PAGE3, UPR_PAGE4: begin
                    rd_kind = UPR_RD_SLOT;
                    wr_kind = UPR_WR_SLOT;
                    case (offset)
                        OFS_0: slot = SLOT_PGS;
                        OFS_1: slot = (page == UPR_PAGE3) ? SLOT_ATG : SLOT_ADF;
                        OFS_2: slot = (page == UPR_PAGE3) ? SLOT_ENH : SLOT_RSND;
                        OFS_4: slot = (page == UPR_PAGE3) ? SLOT_RES1 : SLOT_TXTG;
                        OFS_5: slot = (page == UPR_PAGE3) ? SLOT_RES2 : SLOT_RXTG;
                        OFS_6: slot = (page == UPR_PAGE3) ? SLOT_HLT1 : SLOT_FUP;
                        default: slot = (page == UPR_PAGE3) ? SLOT_HLT2 : SLOT_FLO;
                    endcase
                end
                default: begin
                    rd_kind = UPR_RD_NONE;
                    wr_kind = UPR_WR_NONE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: design/upr_paged_regs.sv */
`default_nettype none
module upr_paged_regs
    import upr_pkg::*;
#(
    parameter int NUM_CHAN = 4,
    parameter int CH_W     = 2
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Host access, same clock domain
    input  wire logic [CH_W-1:0]        chan_sel,
    input  wire logic [2:0]             offset,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    input  wire logic [7:0]             wr_data,
    output var  logic [7:0]             rd_data,
    output var  logic                   rd_valid,
    output var  logic                   access_void,
    // Status from the channel engines
    input  wire logic [NUM_CHAN*8-1:0]  rx_buffer,
    input  wire logic [NUM_CHAN*8-1:0]  irq_status,
    input  wire logic [NUM_CHAN*8-1:0]  line_status,
    input  wire logic [NUM_CHAN*8-1:0]  modem_status,
    input  wire logic [NUM_CHAN*8-1:0]  tx_fifo_count,
    input  wire logic [NUM_CHAN*8-1:0]  rx_fifo_count,
    input  wire logic [NUM_CHAN*8-1:0]  flow_status,
    input  wire logic [7:0]             global_irq_status,
    // Write-only and read side-effect strobes
    output var  logic [7:0]             strobe_data,
    output var  logic [NUM_CHAN-1:0]    tx_holding_wr,
    output var  logic [NUM_CHAN-1:0]    fifo_control_wr,
    output var  logic [NUM_CHAN-1:0]    global_irq_control_wr,
    output var  logic [NUM_CHAN-1:0]    rx_buffer_rd,
    output var  logic [NUM_CHAN-1:0]    irq_status_rd,
    // Stored settings per channel
    output var  logic [NUM_CHAN*16-1:0] baud_divisor,
    output var  logic [NUM_CHAN*8-1:0]  irq_enable,
    output var  logic [NUM_CHAN*8-1:0]  line_control,
    output var  logic [NUM_CHAN*8-1:0]  modem_control,
    output var  logic [NUM_CHAN*8-1:0]  page_select,
    output var  logic [NUM_CHAN*8-1:0]  auto_toggle_control,
    output var  logic [NUM_CHAN*8-1:0]  enhanced_feature,
    output var  logic [NUM_CHAN*8-1:0]  resume_char_1,
    output var  logic [NUM_CHAN*8-1:0]  resume_char_2,
    output var  logic [NUM_CHAN*8-1:0]  halt_char_1,
    output var  logic [NUM_CHAN*8-1:0]  halt_char_2,
    output var  logic [NUM_CHAN*8-1:0]  additional_feature,
    output var  logic [NUM_CHAN*8-1:0]  halt_resend_count,
    output var  logic [NUM_CHAN*8-1:0]  tx_trigger_level,
    output var  logic [NUM_CHAN*8-1:0]  rx_trigger_level,
    output var  logic [NUM_CHAN*8-1:0]  flow_upper_threshold,
    output var  logic [NUM_CHAN*8-1:0]  flow_lower_threshold
);
    logic [7:0]          cfg [NUM_CHAN][NUM_SLOTS];
    logic [7:0]          sel_line;
    logic [7:0]          sel_modem;
    logic [7:0]          sel_page;
    upr_page_e           page;
    upr_rd_e             rd_kind;
    upr_wr_e             wr_kind;
    logic [4:0]          slot;
    logic                do_wr;
    logic                do_rd;
    logic [7:0]          next_rd_data;
    logic [NUM_CHAN-1:0] chan_hot;

    // A write wins when both strobes arrive together; the read is dropped
    assign do_wr = wr_en;
    assign do_rd = rd_en && !wr_en;

    // Page always follows the selected channel's own settings
    assign sel_line  = cfg[chan_sel][SLOT_LIN];
    assign sel_modem = cfg[chan_sel][SLOT_MDM];
    assign sel_page  = cfg[chan_sel][SLOT_PGS];

    upr_page_decode u_decode (
        .line_control   (sel_line),
        .modem_page_bit (sel_modem[MODEM_PG_BIT]),
        .page_bit       (sel_page[SEL_PG_BIT]),
        .offset         (offset),
        .page           (page),
        .rd_kind        (rd_kind),
        .wr_kind        (wr_kind),
        .slot           (slot)
    );

    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            chan_hot[i] = (chan_sel == i[CH_W-1:0]);
        end
    end

    genvar c;
    genvar s;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
                upr_reg8 #(
                    .RESET_VAL (CFG_RESET)
                ) u_reg (
                    .clk   (clk),
                    .rst_n (rst_n),
                    .we    (do_wr && chan_hot[c] && wr_kind == UPR_WR_SLOT
                            && slot == 5'(s)),
                    .d     (wr_data),
                    .q     (cfg[c][s])
                );
            end
            assign baud_divisor[c*16 +: 16]        = {cfg[c][SLOT_DVH], cfg[c][SLOT_DVL]};
            assign irq_enable[c*8 +: 8]            = cfg[c][SLOT_IEN];
            assign line_control[c*8 +: 8]          = cfg[c][SLOT_LIN];
            assign modem_control[c*8 +: 8]         = cfg[c][SLOT_MDM];
            assign page_select[c*8 +: 8]           = cfg[c][SLOT_PGS];
            assign auto_toggle_control[c*8 +: 8]   = cfg[c][SLOT_ATG];
            assign enhanced_feature[c*8 +: 8]      = cfg[c][SLOT_ENH];
            assign resume_char_1[c*8 +: 8]         = cfg[c][SLOT_RES1];
            assign resume_char_2[c*8 +: 8]         = cfg[c][SLOT_RES2];
            assign halt_char_1[c*8 +: 8]           = cfg[c][SLOT_HLT1];
            assign halt_char_2[c*8 +: 8]           = cfg[c][SLOT_HLT2];
            assign additional_feature[c*8 +: 8]    = cfg[c][SLOT_ADF];
            assign halt_resend_count[c*8 +: 8]     = cfg[c][SLOT_RSND];
            assign tx_trigger_level[c*8 +: 8]      = cfg[c][SLOT_TXTG];
            assign rx_trigger_level[c*8 +: 8]      = cfg[c][SLOT_RXTG];
            assign flow_upper_threshold[c*8 +: 8]  = cfg[c][SLOT_FUP];
            assign flow_lower_threshold[c*8 +: 8]  = cfg[c][SLOT_FLO];
        end
    endgenerate

    // Read mux; empty and write-only spots read zero
    always_comb begin
        case (rd_kind)
            UPR_RD_SLOT:  next_rd_data = cfg[chan_sel][slot];
            UPR_RD_RXBUF: next_rd_data = rx_buffer[chan_sel*8 +: 8];
            UPR_RD_ISTAT: next_rd_data = irq_status[chan_sel*8 +: 8];
            UPR_RD_LSTAT: next_rd_data = line_status[chan_sel*8 +: 8];
            UPR_RD_MSTAT: next_rd_data = modem_status[chan_sel*8 +: 8];
            UPR_RD_GSTAT: next_rd_data = global_irq_status;
            UPR_RD_TXCNT: next_rd_data = tx_fifo_count[chan_sel*8 +: 8];
            UPR_RD_RXCNT: next_rd_data = rx_fifo_count[chan_sel*8 +: 8];
            UPR_RD_FSTAT: next_rd_data = flow_status[chan_sel*8 +: 8];
            default:      next_rd_data = RDATA_RESET;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= RDATA_RESET;
        end else if (do_rd) begin
            rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= do_rd;
        end
    end

    // Flags a taken access that hit nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            access_void <= 1'b0;
        end else begin
            access_void <= (do_wr && wr_kind == UPR_WR_NONE)
                        || (do_rd && rd_kind == UPR_RD_NONE);
        end
    end

    // Write data for the strobed targets, held until the next write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_data <= RDATA_RESET;
        end else if (do_wr) begin
            strobe_data <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_holding_wr         <= '0;
            fifo_control_wr       <= '0;
            global_irq_control_wr <= '0;
        end else begin
            tx_holding_wr         <= (do_wr && wr_kind == UPR_WR_TXH) ? chan_hot : '0;
            fifo_control_wr       <= (do_wr && wr_kind == UPR_WR_FIFO) ? chan_hot : '0;
            global_irq_control_wr <= (do_wr && wr_kind == UPR_WR_GCTL) ? chan_hot : '0;
        end
    end

    // Popping the receive buffer or acking status only on a real read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_buffer_rd  <= '0;
            irq_status_rd <= '0;
        end else begin
            rx_buffer_rd  <= (do_rd && rd_kind == UPR_RD_RXBUF) ? chan_hot : '0;
            irq_status_rd <= (do_rd && rd_kind == UPR_RD_ISTAT) ? chan_hot : '0;
        end
    end
endmodule
`default_nettype wire

/* File: sim/upr_paged_regs_props.sv */
`default_nettype none
module upr_paged_regs_props #(
    parameter int NUM_CHAN = 4,
    parameter int CH_W     = 2
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic [CH_W-1:0]       chan_sel,
    input wire logic [2:0]            offset,
    input wire logic                  wr_en,
    input wire logic                  rd_en,
    input wire logic [7:0]            wr_data,
    input wire logic                  rd_valid,
    input wire logic                  access_void,
    input wire logic [7:0]            strobe_data,
    input wire logic [NUM_CHAN-1:0]   tx_holding_wr,
    input wire logic [NUM_CHAN-1:0]   fifo_control_wr,
    input wire logic [NUM_CHAN-1:0]   global_irq_control_wr,
    input wire logic [NUM_CHAN-1:0]   rx_buffer_rd,
    input wire logic [NUM_CHAN*8-1:0] line_control
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Strobe checks look at channel 0 only, where its page bit is visible
    a_read_answer: assert property (rd_en && !wr_en |=> rd_valid) else $error("read lost");
    a_valid_cause: assert property (rd_valid |-> $past(rd_en) && !$past(wr_en))
        else $error("valid without read");
    a_tx_hold_strobe: assert property (tx_holding_wr[0] |-> $past(wr_en) && $past(offset) == 3'h0
        && !$past(line_control[7]) && strobe_data == $past(wr_data)) else $error("bad tx strobe");
    a_fifo_ctl_strobe: assert property (fifo_control_wr[0] |-> $past(wr_en)
        && $past(offset) == 3'h2 && $past(chan_sel) == '0) else $error("bad fifo strobe");
    a_global_ctl_strobe: assert property (global_irq_control_wr[0] |-> $past(wr_en)
        && $past(offset) == 3'h1 && !$past(line_control[7])) else $error("bad global strobe");
    a_rxbuf_pull: assert property (rx_buffer_rd[0] |-> $past(rd_en) && $past(offset) == 3'h0
        && !$past(line_control[7]) && $past(chan_sel) == '0) else $error("bad rx pull");
    a_line_ctl_write: assert property (wr_en && offset == 3'h3 && chan_sel == '0
        |=> line_control[7:0] == $past(wr_data)) else $error("line control not written");
    a_void_cause: assert property (access_void |-> $past(wr_en) || $past(rd_en))
        else $error("void without access");
endmodule
bind upr_paged_regs upr_paged_regs_props #(.NUM_CHAN(NUM_CHAN), .CH_W(CH_W))
    upr_paged_regs_props_inst (.clk, .rst_n, .chan_sel, .offset, .wr_en, .rd_en, .wr_data,
    .rd_valid, .access_void, .strobe_data, .tx_holding_wr, .fifo_control_wr,
    .global_irq_control_wr, .rx_buffer_rd, .line_control);
`default_nettype wire

/* File: sim/upr_host_model.sv */
`default_nettype none
module upr_host_model #(
    parameter int CH_W = 2
) (
    input  wire logic            clk,
    output var  logic [CH_W-1:0] chan_sel,
    output var  logic [2:0]      offset,
    output var  logic            wr_en,
    output var  logic            rd_en,
    output var  logic [7:0]      wr_data,
    input  wire logic [7:0]      rd_data,
    input  wire logic            rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {chan_sel, offset, wr_en, rd_en, wr_data} = '0;
    end
    // Request moves 1 ns after an edge and holds through the taking edge
    task automatic req(input logic [CH_W-1:0] c, input logic [2:0] o, input logic w,
                       input logic [7:0] d);
        @(posedge clk);
        #1 {chan_sel, offset, wr_en, rd_en, wr_data} = {c, o, w, !w, d};
        @(posedge clk);
        // Released data must not look still valid
        #1 {wr_en, rd_en, wr_data} = {2'h0, ~d};
    endtask
    task automatic wr(input logic [CH_W-1:0] c, input logic [2:0] o, input logic [7:0] d);
        req(c, o, 1'h1, d);
    endtask
    task automatic rd(input logic [CH_W-1:0] c, input logic [2:0] o, output logic [7:0] q,
                      output logic v);
        req(c, o, 1'h0, 8'h00);
        {q, v} = {rd_data, rd_valid};
    endtask
endmodule
`default_nettype wire

/* File: sim/test_upr_paged_regs.sv */
`default_nettype none
module test_upr_paged_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, wr_en, rd_en, rd_valid, access_void;
    logic [1:0]  chan_sel, ch;
    logic [2:0]  offset;
    logic [7:0]  wr_data, rd_data, stat, strobe_data;
    logic [3:0]  tx_holding_wr, fifo_control_wr, global_irq_control_wr;
    logic [3:0]  rx_buffer_rd, irq_status_rd;
    logic [63:0] baud_divisor;
    logic [31:0] irq_enable, line_control, modem_control, page_select, auto_toggle_control;
    logic [31:0] enhanced_feature, resume_char_1, resume_char_2, halt_char_1, halt_char_2;
    logic [31:0] additional_feature, halt_resend_count, tx_trigger_level, rx_trigger_level;
    logic [31:0] flow_upper_threshold, flow_lower_threshold;
    int          err_total, samples_checked;
    // Status inputs follow stat so every source reads back distinctly
    upr_paged_regs #(.NUM_CHAN(4), .CH_W(2)) upr_paged_regs_inst (
        .clk, .rst_n, .chan_sel, .offset, .wr_en, .rd_en, .wr_data, .rd_data, .rd_valid,
        .access_void, .rx_buffer({4{stat ^ 8'h01}}), .irq_status({4{stat ^ 8'h02}}),
        .line_status({4{stat ^ 8'h03}}), .modem_status({4{stat ^ 8'h04}}),
        .tx_fifo_count({4{stat ^ 8'h05}}), .rx_fifo_count({4{stat ^ 8'h06}}),
        .flow_status({4{stat ^ 8'h07}}), .global_irq_status(stat ^ 8'h08), .strobe_data,
        .tx_holding_wr, .fifo_control_wr, .global_irq_control_wr, .rx_buffer_rd,
        .irq_status_rd, .baud_divisor, .irq_enable, .line_control, .modem_control,
        .page_select, .auto_toggle_control, .enhanced_feature, .resume_char_1, .resume_char_2,
        .halt_char_1, .halt_char_2, .additional_feature, .halt_resend_count,
        .tx_trigger_level, .rx_trigger_level, .flow_upper_threshold, .flow_lower_threshold);
    upr_host_model #(.CH_W(2)) upr_host_model_inst (
        .clk, .chan_sel, .offset, .wr_en, .rd_en, .wr_data, .rd_data, .rd_valid);
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) $display("ERROR %s expected %h seen %h", n, exp, seen);
        if (seen !== exp) err_total++;
    endtask
    task automatic w(input logic [2:0] o, input logic [7:0] d);
        upr_host_model_inst.wr(ch, o, d);
    endtask
    task automatic rc(input logic [2:0] o, input logic [7:0] exp, input logic vd);
        logic [7:0] q;
        logic       v;
        upr_host_model_inst.rd(ch, o, q, v);
        chk("rd_data", q, exp);
        chk("valid_void", {6'h0, v, access_void}, {6'h0, 1'h1, vd});
    endtask
    task automatic fill(input logic [7:0] base);
        for (int i = 1; i < 8; i++) begin
            if (i == 3) continue;
            w(3'(i), base + 8'(i));
            rc(3'(i), base + 8'(i), 1'h0);
        end
    endtask
    task automatic s_page0;
        w(3'h0, 8'ha5);
        chk("tx_strobe", {4'h0, tx_holding_wr}, 8'h01);
        chk("strobe_data", strobe_data, 8'ha5);
        rc(3'h0, 8'h51, 1'h0);
        chk("rx_pull", {4'h0, rx_buffer_rd}, 8'h01);
        w(3'h2, 8'hc7);
        chk("fifo_strobe", {4'h0, fifo_control_wr}, 8'h01);
        rc(3'h2, 8'h52, 1'h0);
        chk("status_ack", {4'h0, irq_status_rd}, 8'h01);
        w(3'h1, 8'h0f);
        rc(3'h1, 8'h0f, 1'h0);
        w(3'h5, 8'hff);
        chk("ro_write", {7'h0, access_void}, 8'h01);
        rc(3'h5, 8'h53, 1'h0);
        rc(3'h6, 8'h54, 1'h0);
        w(3'h7, 8'h3c);
        rc(3'h7, 8'h3c, 1'h0);
    endtask
    task automatic s_page1;
        w(3'h3, 8'hbe);
        w(3'h0, 8'h34);
        w(3'h1, 8'h12);
        chk("div_low", baud_divisor[7:0], 8'h34);
        chk("div_high", baud_divisor[15:8], 8'h12);
        chk("irq_en", irq_enable[7:0], 8'h0f);
        w(3'h4, 8'h4b);
        rc(3'h4, 8'h4b, 1'h0);
        rc(3'h2, 8'h52, 1'h0);
    endtask
    task automatic s_page2;
        stat = 8'h60;
        w(3'h3, 8'h00);
        w(3'h0, 8'h77);
        chk("empty_write", {3'h0, tx_holding_wr, access_void}, 8'h01);
        rc(3'h0, 8'h00, 1'h1);
        w(3'h1, 8'h99);
        chk("global_strobe", {4'h0, global_irq_control_wr}, 8'h01);
        rc(3'h1, 8'h00, 1'h1);
        rc(3'h2, 8'h68, 1'h0);
        rc(3'h5, 8'h65, 1'h0);
        rc(3'h6, 8'h66, 1'h0);
        rc(3'h4, 8'h4b, 1'h0);
        rc(3'h7, 8'h67, 1'h0);
    endtask
    task automatic s_enhanced;
        w(3'h3, 8'hbf);
        w(3'h0, 8'h00);
        fill(8'h30);
        w(3'h0, 8'h01);
        fill(8'h40);
        chk("auto_toggle", auto_toggle_control[7:0], 8'h31);
        chk("enh_feature", enhanced_feature[7:0], 8'h32);
        chk("resume_1", resume_char_1[7:0], 8'h34);
        chk("resume_2", resume_char_2[7:0], 8'h35);
        chk("halt_1", halt_char_1[7:0], 8'h36);
        chk("halt_2", halt_char_2[7:0], 8'h37);
        chk("add_feature", additional_feature[7:0], 8'h41);
        chk("resend", halt_resend_count[7:0], 8'h42);
        chk("tx_trig", tx_trigger_level[7:0], 8'h44);
        chk("rx_trig", rx_trigger_level[7:0], 8'h45);
        chk("flow_upper", flow_upper_threshold[7:0], 8'h46);
        chk("page_sel", page_select[7:0], 8'h01);
        chk("flow_lower", flow_lower_threshold[7:0], 8'h47);
        chk("modem_ctl", modem_control[7:0], 8'h4b);
        rc(3'h0, 8'h01, 1'h0);
    endtask
    task automatic s_channel;
        ch = 2'h2;
        w(3'h7, 8'h5a);
        rc(3'h7, 8'h5a, 1'h0);
        chk("line_ctl_ch0", line_control[7:0], 8'hbf);
        ch = 2'h0;
        rc(3'h7, 8'h47, 1'h0);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        {err_total, samples_checked} = '0;
        {ch, stat, rst_n} = {2'h0, 8'h50, 1'h0};
        repeat (10) @(posedge clk);
        #1 rst_n = 1'h1;
        chk("line_ctl_rst", line_control[7:0], 8'h00);
        s_page0();
        s_page1();
        s_page2();
        s_enhanced();
        s_channel();
        report_and_stop();
    end
endmodule
`default_nettype wire
